//--- tmr_ctl_consts.svh
/*
 Register offsets, field positions and reset values of the timer
 start, access-protection and output-enable register bank.
 Assumes it is included by its bare name from the design file.
*/
// Contract
// - Sync select bits 7..3 mark counters 0..4.
// - Select bits set by writing 1 only.
// - Counter run set clears its select bit.
// - Reserved low bits read zero.
// - Access enable flag bit 0, resets to 1.
// - Write 0 clears flag only after read-1.
// - Flag guards the 22 channel 3/4 registers.
// - Output enable bits 7,6 read as 1.
// - Output enable bits 5..0 map six pins.
// - Disabled pin drives chosen inactive level.
// - Outside PWM modes disabled pin outputs low.
// - Run register bits 7,6,2,1,0 run counters.
`ifndef TMR_CTL_CONSTS_SVH
`define TMR_CTL_CONSTS_SVH

`define OFS_RUN 4'h0
`define OFS_SYNC 4'h1
`define OFS_PROT 4'h2
`define OFS_OUTEN 4'h3

`define SYNC_RST 5'h00
`define RUN_RST 5'h00
`define OUTEN_RST 6'h00
`define PROT_RST 1'h1
`define OUTEN_RSV 2'h3
`define SYNC_LSB 3
`define RUN_MASK 8'hc7

`endif

//--- tmr_ctl_pkg.sv
/*
 Types shared by the timer control register bank.
 Assumes no surroundings beyond the design file that refers to it.
*/
`default_nettype none
package tmr_ctl_pkg;
	typedef logic [7:0] byte_type;
	typedef logic [4:0] chan_type;
endpackage
`default_nettype wire

//--- tmr_ctl.sv
/*
 Timer control register bank: counter run register, synchronous start
 select, access-protection flag and output master enable with pin gating.
 Assumes a single-cycle register port master on i_clk; counters and PWM
 logic sit outside and consume o_run_ch and o_guard_en.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tmr_ctl_consts.svh"
module tmr_ctl #(
	parameter int NUM_CH = 5,
	parameter int NUM_PINS = 6
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_pwm_mode,
	input wire logic [5:0] i_inactive_lvl,
	input wire logic [5:0] i_timer_out,
	output logic [5:0] o_pin,
	output logic [4:0] o_run_ch,
	output logic o_guard_en
);
	tmr_ctl_pkg::chan_type run_r;
	tmr_ctl_pkg::chan_type sync_r;
	logic prot_r;
	logic prot_armed_r;
	logic [5:0] outen_r;
	tmr_ctl_pkg::byte_type rdata_r;
	tmr_ctl_pkg::chan_type sync_wr_bits;
	tmr_ctl_pkg::chan_type run_wr_bits;
	tmr_ctl_pkg::chan_type sync_sel;
	tmr_ctl_pkg::chan_type run_nxt;
	logic wr_run, wr_sync, wr_prot, wr_outen;

	// ----------------------------------------------------------------
	// Configuration check
	// ----------------------------------------------------------------
	// The bit layout of all three registers is fixed, so the counts may not move.
	generate
		if (NUM_CH != 5 || NUM_PINS != 6) begin : g_bad_cfg
			$error("tmr_ctl serves five counters and six pins only");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wr_run = i_wr && (i_addr == `OFS_RUN);
	assign wr_sync = i_wr && (i_addr == `OFS_SYNC);
	assign wr_prot = i_wr && (i_addr == `OFS_PROT);
	assign wr_outen = i_wr && (i_addr == `OFS_OUTEN) && prot_r;

	// Select register bit 7 is counter 0, so the field is reversed.
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_sel_map
			assign sync_wr_bits[c] = i_wdata[`SYNC_LSB + NUM_CH - 1 - c];
		end
	endgenerate
	// The run field has a hole at bits 5..3, so it is gathered by hand.
	assign run_wr_bits = {i_wdata[7], i_wdata[6], i_wdata[2], i_wdata[1], i_wdata[0]};

	// A select write starts every counter whose select bit ends up set.
	assign sync_sel = wr_sync ? (sync_r | sync_wr_bits) : 5'h00;

	always_comb begin
		run_nxt = run_r;
		if (wr_run) begin
			run_nxt = run_wr_bits;
		end
		run_nxt = run_nxt | sync_sel;
	end

	// ----------------------------------------------------------------
	// Counter run register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_r <= `RUN_RST;
		end else begin
			run_r <= run_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Synchronous start select
	// ----------------------------------------------------------------
	// The select bits clear on the same edge that raises the run bits, so
	// a set never lingers past the start it requested.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_r <= `SYNC_RST;
		end else begin
			sync_r <= (sync_r | (wr_sync ? sync_wr_bits : 5'h00))
				& ~(run_nxt & ~run_r) & ~sync_sel;
		end
	end

	// ----------------------------------------------------------------
	// Access protection flag
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prot_r <= `PROT_RST;
			prot_armed_r <= 1'b0;
		end else begin
			if (i_rd && i_addr == `OFS_PROT && prot_r) begin
				prot_armed_r <= 1'b1;
			end
			if (wr_prot) begin
				if (!i_wdata[0] && prot_armed_r) begin
					prot_r <= 1'b0;
				end else if (i_wdata[0]) begin
					prot_r <= 1'b1;
				end
				prot_armed_r <= 1'b0;
			end
		end
	end

	assign o_guard_en = prot_r;

	// ----------------------------------------------------------------
	// Output master enable and pin gating
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			outen_r <= `OUTEN_RST;
		end else if (wr_outen) begin
			outen_r <= i_wdata[5:0];
		end
	end

	// Pins: bit 5..0 = 4D, 4C, 3D, 4B, 4A, 3B.
	// Each pin level is registered, so the pad never glitches while the
	// enable bit or the mode input changes; the cost is one cycle of delay.
	generate
		for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
			logic pin_r;
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					pin_r <= 1'b0;
				end else if (outen_r[p]) begin
					pin_r <= i_timer_out[p];
				end else if (i_pwm_mode) begin
					pin_r <= i_inactive_lvl[p];
				end else begin
					pin_r <= 1'b0;
				end
			end
			assign o_pin[p] = pin_r;
		end
	endgenerate

	assign o_run_ch = run_r;

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Guarded output enable reads as reserved ones only while locked.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				`OFS_RUN: rdata_r <= {run_r[4], run_r[3], 3'h0, run_r[2:0]};
				`OFS_SYNC: rdata_r <= {sync_r[0], sync_r[1], sync_r[2], sync_r[3], sync_r[4], 3'h0};
				`OFS_PROT: rdata_r <= {7'h00, prot_r};
				`OFS_OUTEN: rdata_r <= {`OUTEN_RSV, prot_r ? outen_r : 6'h00};
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end
	assign o_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sync_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_sync && i_wdata[7] |=> run_r[0] && !sync_r[0])
		else $error("select did not start counter 0");
	sync_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		sync_r[1] && !run_nxt[1] |=> sync_r[1])
		else $error("select bit lost");
	prot_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_prot && !i_wdata[0] && !prot_armed_r && prot_r |=> prot_r)
		else $error("flag cleared without read");
	outen_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!prot_r |=> $stable(outen_r))
		else $error("locked enable changed");
	rsv_ones_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_OUTEN |=> o_rdata[7:6] == 2'h3)
		else $error("reserved bits not one");
	prot_rsv_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_PROT |=> o_rdata[7:1] == 7'h00)
		else $error("reserved bits not zero");
	pin_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!outen_r[0] && !i_pwm_mode |=> !o_pin[0])
		else $error("disabled pin not low");
	pin_inact_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!outen_r[5] && i_pwm_mode |=> o_pin[5] == $past(i_inactive_lvl[5]))
		else $error("inactive level wrong");
	run_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_run && !wr_sync |=> run_r[4] == $past(i_wdata[7]))
		else $error("run bit 4 wrong");
	run_write_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_run |=> run_r[0] == $past(i_wdata[0]))
		else $error("run bit 0 wrong");
	run_write_ch3_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_run |=> run_r[3] == $past(i_wdata[6]))
		else $error("run bit 3 wrong");
	run_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!wr_run && !wr_sync |=> run_r == $past(run_r))
		else $error("run bits moved without write");
	run_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_RUN |=> (o_rdata & ~`RUN_MASK) == 8'h00)
		else $error("run reserved bits not zero");

	// Every select bit must start its own counter; a crossed wire in the
	// reversed field would start the wrong channel.
	sync_start_ch1_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_sync && i_wdata[6] |=> run_r[1])
		else $error("select did not start counter 1");
	sync_start_ch2_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_sync && i_wdata[5] |=> run_r[2])
		else $error("select did not start counter 2");
	sync_start_ch3_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_sync && i_wdata[4] |=> run_r[3])
		else $error("select did not start counter 3");
	sync_start_ch4_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_sync && i_wdata[3] |=> run_r[4])
		else $error("select did not start counter 4");
	sync_zero_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_sync && i_wdata[7:3] == 5'h00 |=> run_r == $past(run_r) && sync_r == $past(sync_r))
		else $error("select write of zero changed state");
	sync_clear_all_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_sync |=> sync_r == 5'h00)
		else $error("select bit lingered after start");
	run_clear_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_run && i_wdata[0] |=> !sync_r[0])
		else $error("run write left select set");
	sync_read_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_SYNC |=> o_rdata[2:0] == 3'h0)
		else $error("select low bits not zero");

	// The flag may only drop through the read-then-write-zero sequence.
	prot_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_prot && i_wdata[0] |=> prot_r)
		else $error("flag not set by write of one");
	prot_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!wr_prot |=> prot_r == $past(prot_r))
		else $error("flag moved without write");
	prot_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_PROT |=> o_rdata[0] == $past(prot_r))
		else $error("flag read wrong");
	prot_arm_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_prot && !i_wdata[0] && prot_armed_r |=> !prot_r)
		else $error("armed flag not cleared");
	armed_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_PROT && prot_r |=> prot_armed_r)
		else $error("read of one did not arm");
	armed_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_prot |=> !prot_armed_r)
		else $error("flag write left arm set");

	// Output enable is guarded: locked reads show only the reserved ones.
	outen_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_outen |=> outen_r == $past(i_wdata[5:0]))
		else $error("enable write lost");
	outen_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_OUTEN && !prot_r |=> o_rdata == 8'hc0)
		else $error("locked enable read leaked");
	outen_show_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == `OFS_OUTEN && prot_r |=> o_rdata[5:0] == $past(outen_r))
		else $error("enable read wrong");

	// Pin checks sample one edge later because every pin is registered.
	pin_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		outen_r[3] |=> o_pin[3] == $past(i_timer_out[3]))
		else $error("enabled pin not following timer");
	pin_on_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		outen_r[0] |=> o_pin[0] == $past(i_timer_out[0]))
		else $error("enabled pin 0 not following timer");
	pin_low_top_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!outen_r[5] && !i_pwm_mode |=> !o_pin[5])
		else $error("disabled top pin not low");
	pin_inact_mid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!outen_r[2] && i_pwm_mode |=> o_pin[2] == $past(i_inactive_lvl[2]))
		else $error("middle inactive level wrong");
	sync_run_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_run && i_wdata[7] |=> !sync_r[4])
		else $error("run write left select 4 set");
endmodule
`default_nettype wire

//--- timer_sync_start_protect_output_enable_tb.sv
/*
 Self-checking testbench for the timer control register bank.
 Assumes tmr_ctl and its constants header are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_sync_start_protect_output_enable_tb;
	logic i_clk, i_rst_n, i_wr, i_rd, i_pwm_mode, o_guard_en;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata;
	logic [5:0] i_inactive_lvl, i_timer_out, o_pin;
	logic [4:0] o_run_ch;
	int num_errors = 0;
	int check_count = 0;
	tmr_ctl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_mode(i_pwm_mode), .i_inactive_lvl(i_inactive_lvl),
		.i_timer_out(i_timer_out), .o_pin(o_pin), .o_run_ch(o_run_ch), .o_guard_en(o_guard_en));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	task automatic pins(input logic pwm, input logic [5:0] exp);
		@(posedge i_clk);
		i_pwm_mode <= pwm;
		repeat (2) @(posedge i_clk);
		#1;
		chk({2'h0, o_pin}, {2'h0, exp});
	endtask
	task automatic complete_run;
		if (num_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_pwm_mode = 1'b0;
		i_inactive_lvl = 6'h1a;
		i_timer_out = 6'h2f;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h01);
		rd(4'h3, 8'hc0);
		rd(4'hf, 8'h00);
		wr(4'h1, 8'h90);
		chk({3'h0, o_run_ch}, 8'h09);
		rd(4'h1, 8'h00);
		rd(4'h0, 8'h41);
		wr(4'h1, 8'h00);
		rd(4'h0, 8'h41);
		wr(4'h0, 8'hc7);
		rd(4'h0, 8'hc7);
		chk({3'h0, o_run_ch}, 8'h1f);
		wr(4'h0, 8'h00);
		chk({3'h0, o_run_ch}, 8'h00);
		wr(4'h3, 8'hc5);
		rd(4'h3, 8'hc5);
		pins(1'b0, 6'h05);
		pins(1'b1, 6'h1f);
		// Writing 1 disarms the flag, so the following 0 must not clear it.
		wr(4'h2, 8'h01);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h01);
		wr(4'h2, 8'h00);
		chk({7'h0, o_guard_en}, 8'h00);
		rd(4'h2, 8'h00);
		wr(4'h3, 8'hff);
		rd(4'h3, 8'hc0);
		wr(4'h2, 8'h01);
		rd(4'h3, 8'hc5);
		// A reset in mid-run must restore the flag and drop every enable.
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		i_pwm_mode <= 1'b0;
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		chk({7'h0, o_guard_en}, 8'h01);
		chk({3'h0, o_run_ch}, 8'h00);
		chk({2'h0, o_pin}, 8'h00);
		rd(4'h3, 8'hc0);
		complete_run();
	end
	initial begin
		repeat (1000) @(posedge i_clk);
		num_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
